// [hw/hpspc_map.svh]
`ifndef HPSPC_MAP_SVH
`define HPSPC_MAP_SVH

`define HPSPC_NUM_PORTS        7
`define HPSPC_DETECT_TIME_NS   1000
`define HPSPC_CLK_PERIOD_NS    100
`define HPSPC_DETECT_CYCLES    ((`HPSPC_DETECT_TIME_NS + `HPSPC_CLK_PERIOD_NS - 1) / `HPSPC_CLK_PERIOD_NS)
`define HPSPC_STRAP_DIS_LEVEL  1'b1
`define HPSPC_PULLUP_RESET     1'b0
`define HPSPC_DISABLE_RESET    7'h00

`endif

// [hw/hpspc_pkg.sv]
package hpspc_pkg;

    typedef enum logic [1:0] {
        HPSPC_ST_DETACHED,
        HPSPC_ST_DEBOUNCE,
        HPSPC_ST_ATTACHED
    } hpspc_conn_t;

    typedef struct packed {
        logic [6:0] plus;
        logic [6:0] minus;
    } hpspc_strap_t;

endpackage : hpspc_pkg

// [hw/hpspc_strap_capture.sv]
`timescale 1ns/1ps
`include "hpspc_map.svh"

// takes one sample per port on the first edge after reset release, then freezes
module hpspc_strap_capture
    import hpspc_pkg::*;
#(
    parameter int NUM_PORTS = `HPSPC_NUM_PORTS
)
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // strap pins and enable
    input  wire logic                 strapEnable,
    input  wire logic [NUM_PORTS-1:0] strapPin,
    // result
    output logic      [NUM_PORTS-1:0] portDisabled,
    output logic                      captured
);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            captured     <= 1'b0;
            portDisabled <= NUM_PORTS'(`HPSPC_DISABLE_RESET);
        end
        else if (!captured)
        begin
            captured <= 1'b1;
            // high level on the strap means the port is disabled
            portDisabled <= strapEnable ? (strapPin ~^ {NUM_PORTS{`HPSPC_STRAP_DIS_LEVEL}})
                                        : '0;
        end
    end

endmodule : hpspc_strap_capture

// [hw/hpspc_port_control.sv]
`timescale 1ns/1ps
`include "hpspc_map.svh"

module hpspc_port_control
    import hpspc_pkg::*;
#(
    parameter int NUM_PORTS      = `HPSPC_NUM_PORTS,
    parameter int DETECT_CYCLES  = `HPSPC_DETECT_CYCLES
)
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // upstream side
    input  wire logic                 upstream_power_detect,
    output logic                      upstreamPullupEnable,
    // strap configuration
    input  wire logic                 strapEnable,
    input  wire hpspc_strap_t         strapPins,
    // power request from hub logic, per port
    input  wire logic [NUM_PORTS-1:0] portPowerRequest,
    // downstream side
    output logic      [NUM_PORTS-1:0] port_power_enable_out,
    output logic      [NUM_PORTS-1:0] portDisabled,
    output logic                      strapsValid
);

    localparam int CW = $clog2(DETECT_CYCLES + 1);

    // refuse sizes the strap carrier or the filter counter cannot serve
    if (NUM_PORTS < 1 || NUM_PORTS > 7)
    begin : g_bad_ports
        $error("NUM_PORTS must be 1..7");
    end
    if (DETECT_CYCLES < 1)
    begin : g_bad_detect
        $error("DETECT_CYCLES must be at least 1");
    end

    // filter end point, shared by the counter and the state register
    function automatic logic f_filter_done(input logic [CW-1:0] count);
        f_filter_done = (count >= CW'(DETECT_CYCLES));
    endfunction : f_filter_done

    // saturating step, so a long filter never wraps back below the end point
    function automatic logic [CW-1:0] f_count_step(input logic [CW-1:0] count);
        f_count_step = f_filter_done(count) ? count : count + CW'(1);
    endfunction : f_count_step

    // a port powers only once its strap is known and it is not disabled
    function automatic logic [NUM_PORTS-1:0] f_power_mask(
        input logic                 done,
        input logic [NUM_PORTS-1:0] request,
        input logic [NUM_PORTS-1:0] disabled
    );
        f_power_mask = done ? (request & ~disabled) : '0;
    endfunction : f_power_mask

    hpspc_conn_t          connState;
    logic [CW-1:0]        detectCount;
    logic [NUM_PORTS-1:0] strapPlusLane;
    logic [NUM_PORTS-1:0] capDisabled;
    logic                 capDone;

    // only the data-plus lanes carry the disable level
    assign strapPlusLane = strapPins.plus[NUM_PORTS-1:0];

    // data-plus strap carries the disable level; the minus strap is not used
    hpspc_strap_capture #(
        .NUM_PORTS (NUM_PORTS)
    ) u_capture (
        .clk          (clk),
        .rstn         (rstn),
        .strapEnable  (strapEnable),
        .strapPin     (strapPlusLane),
        .portDisabled (capDisabled),
        .captured     (capDone)
    );

    // counter runs only while detect is seen high; any low restarts the filter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            detectCount <= '0;
        else if (!upstream_power_detect)
            detectCount <= '0;
        else if (connState == HPSPC_ST_DETACHED)
            detectCount <= CW'(1);
        else if (connState == HPSPC_ST_DEBOUNCE)
            detectCount <= f_count_step(detectCount);
    end

    // detect must stay high for the filter time before connect is signalled
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            connState <= HPSPC_ST_DETACHED;
        else
        begin
            unique case (connState)
                HPSPC_ST_DETACHED:
                    if (upstream_power_detect)
                        connState <= HPSPC_ST_DEBOUNCE;
                HPSPC_ST_DEBOUNCE:
                    if (!upstream_power_detect)
                        connState <= HPSPC_ST_DETACHED;
                    else if (f_filter_done(detectCount))
                        connState <= HPSPC_ST_ATTACHED;
                HPSPC_ST_ATTACHED:
                    if (!upstream_power_detect)
                        connState <= HPSPC_ST_DETACHED;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            upstreamPullupEnable <= `HPSPC_PULLUP_RESET;
        else
            upstreamPullupEnable <= (connState == HPSPC_ST_ATTACHED) && upstream_power_detect;
    end

    // power only flows once straps are known; a disabled port never powers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            port_power_enable_out <= '0;
        else
            port_power_enable_out <= f_power_mask(capDone, portPowerRequest, capDisabled);
    end

    // loaded once per reset; later strap pin activity never reaches the status
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            portDisabled <= '0;
        else if (capDone && !strapsValid)
            portDisabled <= capDisabled;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            strapsValid <= 1'b0;
        else
            strapsValid <= capDone;
    end

endmodule : hpspc_port_control

// [test/hpspc_far_model.sv]
`timescale 1ns/1ps
module hpspc_far_model
    import hpspc_pkg::*;
(
    // fitted strap pull-ups
    input  wire logic [6:0] disMask,
    // pin levels at the hub
    output hpspc_strap_t    strapPins
);
    // unfitted lines sit on the hub pull-down
    assign strapPins.plus  = disMask;
    assign strapPins.minus = 7'h00;
endmodule : hpspc_far_model

// [test/hpspc_port_control_assertions.sv]
`timescale 1ns/1ps
module hpspc_port_control_chk
    import hpspc_pkg::*;
#(parameter int NUM_PORTS = 7, parameter int DETECT_CYCLES = 10)
(
    // all ports watched
    input wire logic                 clk,
    input wire logic                 rstn,
    input wire logic                 upstream_power_detect,
    input wire logic                 upstreamPullupEnable,
    input wire logic                 strapEnable,
    input wire hpspc_strap_t         strapPins,
    input wire logic [NUM_PORTS-1:0] portPowerRequest,
    input wire logic [NUM_PORTS-1:0] port_power_enable_out,
    input wire logic [NUM_PORTS-1:0] portDisabled,
    input wire logic                 strapsValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] hiCnt;
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) hiCnt <= 8'h00;
        else if (!upstream_power_detect) hiCnt <= 8'h00;
        else if (hiCnt != 8'hff) hiCnt <= hiCnt + 8'h01;
    property p_rst;
        $rose(rstn) |-> !upstreamPullupEnable && !strapsValid && port_power_enable_out == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_cap;
        $rose(strapsValid) |-> portDisabled ==
            ($past(strapPins.plus[NUM_PORTS-1:0], 2) & {NUM_PORTS{$past(strapEnable, 2)}});
    endproperty
    a_cap: assert property (p_cap) else $error("strap capture wrong");
    property p_hold;
        strapsValid |=> strapsValid && $stable(portDisabled);
    endproperty
    a_hold: assert property (p_hold) else $error("straps changed");
    property p_pwr;
        strapsValid |=> port_power_enable_out == ($past(portPowerRequest) & ~portDisabled);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power enable wrong");
    property p_gate;
        !strapsValid |-> port_power_enable_out == '0;
    endproperty
    a_gate: assert property (p_gate) else $error("power before capture");
    property p_up;
        upstreamPullupEnable == (hiCnt >= DETECT_CYCLES + 2);
    endproperty
    a_up: assert property (p_up) else $error("pull-up timing wrong");
    c_dis: cover property (strapsValid && |portDisabled);
    c_up: cover property (upstreamPullupEnable);
    c_pwr: cover property (|port_power_enable_out);
endmodule : hpspc_port_control_chk
bind hpspc_port_control hpspc_port_control_chk #(.NUM_PORTS(NUM_PORTS),
    .DETECT_CYCLES(DETECT_CYCLES)) i_chk (.clk(clk), .rstn(rstn),
    .upstream_power_detect(upstream_power_detect), .upstreamPullupEnable(upstreamPullupEnable),
    .strapEnable(strapEnable), .strapPins(strapPins), .portPowerRequest(portPowerRequest),
    .port_power_enable_out(port_power_enable_out), .portDisabled(portDisabled),
    .strapsValid(strapsValid));

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    import hpspc_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, det = 1'b0, en = 1'b0, up, ok;
    logic [6:0] mask = 7'h00, req = 7'h7f, pwr, dis;
    hpspc_strap_t pins;
    int miscompares = 0;
    int total_checks = 0;
    always #50 clk = ~clk;
    hpspc_far_model i_far (.disMask(mask), .strapPins(pins));
    hpspc_port_control #(.DETECT_CYCLES(1)) i_dut (.clk(clk), .rstn(rstn),
        .upstream_power_detect(det), .upstreamPullupEnable(up), .strapEnable(en),
        .strapPins(pins), .portPowerRequest(req), .port_power_enable_out(pwr),
        .portDisabled(dis), .strapsValid(ok));
    task automatic chk(input logic [6:0] g, input logic [6:0] e);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic t_straps(input logic e, input logic [6:0] m);
        @(posedge clk);
        rstn <= 1'b0;
        en <= e;
        mask <= m;
        req <= 7'h7f;
        tick(4);
        @(posedge clk);
        rstn <= 1'b1;
        tick(1);
        chk(pwr, 7'h00);
        tick(2);
        chk({6'h00, ok}, 7'h01);
        chk(dis, e ? m : 7'h00);
        @(posedge clk);
        mask <= ~m;
        en <= ~e;
        req <= 7'h3c;
        tick(1);
        chk(pwr, e ? 7'h3c & ~m : 7'h3c);
        tick(2);
        chk(dis, e ? m : 7'h00);
    endtask : t_straps
    task automatic t_connect();
        @(posedge clk);
        det <= 1'b1;
        @(posedge clk);
        det <= 1'b0;
        tick(3);
        chk({6'h00, up}, 7'h00);
        @(posedge clk);
        det <= 1'b1;
        tick(2);
        chk({6'h00, up}, 7'h00);
        tick(2);
        chk({6'h00, up}, 7'h01);
        @(posedge clk);
        det <= 1'b0;
        tick(2);
        chk({6'h00, up}, 7'h00);
    endtask : t_connect
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial
    begin
        t_straps(1'b1, 7'h55);
        t_connect();
        t_straps(1'b0, 7'h7f);
        stop_test();
    end
    initial
    begin
        #400000;
        miscompares++;
        stop_test();
    end
endmodule : tb
